/* File: core/dspm_pin_mux.sv */
// Pin function mux for port B pin two, port C pins two to four and debug clock
`timescale 1ns/1ps
module dspm_pin_mux (
	input  wire logic                                ref_clk,
	input  wire logic                                rst_n,
	input  wire logic                                debug_link_clk,
	input  wire logic                                external_reset_n,
	// Configuration levels
	input  wire logic [1:0]                          ctrl1_mode_select,
	input  wire logic                                ctrl1_spi_config,
	input  wire logic                                timer_two_output_enable,
	input  wire logic [dspm_pkg::REMAP_W-1:0]        timer_two_remap_option,
	input  wire logic [dspm_pkg::CFG_W-1:0]          port_a_config_low,
	input  wire logic [dspm_pkg::CFG_W-1:0]          port_b_config_low,
	input  wire logic [dspm_pkg::CFG_W-1:0]          port_c_config_low,
	input  wire logic [dspm_pkg::CFG_W-1:0]          port_c_config_high,
	input  wire logic [dspm_pkg::DBG_CFG_W-1:0]      debug_pin_config,
	input  wire logic                                trace_enable,
	input  wire logic                                trace_async_select,
	input  wire logic                                trace_sync4_select,
	// Peripheral and core outputs toward pins
	input  wire logic                                ctrl1_twowire_clock_low,
	input  wire logic                                timer_two_channel_two_out,
	input  wire logic                                boundary_test_data_out,
	input  wire logic                                boundary_test_data_out_en,
	input  wire logic                                async_trace_out,
	input  wire logic                                sync_trace_data_zero,
	input  wire logic                                sync_trace_clock,
	input  wire logic                                wire_data_out,
	input  wire logic                                wire_data_out_en,
	input  wire logic [3:0]                          gpio_out,
	input  wire logic [3:0]                          gpio_out_en,
	// Pins
	input  wire logic                                port_b_pin_two_i,
	output logic                                     port_b_pin_two_o,
	output logic                                     port_b_pin_two_oe,
	output logic                                     port_b_pin_two_pu,
	output logic                                     port_b_pin_two_pd,
	input  wire logic                                port_c_pin_two_i,
	output logic                                     port_c_pin_two_o,
	output logic                                     port_c_pin_two_oe,
	output logic                                     port_c_pin_two_pu,
	output logic                                     port_c_pin_two_pd,
	input  wire logic                                port_c_pin_three_i,
	output logic                                     port_c_pin_three_o,
	output logic                                     port_c_pin_three_oe,
	output logic                                     port_c_pin_three_pu,
	output logic                                     port_c_pin_three_pd,
	input  wire logic                                port_c_pin_four_i,
	output logic                                     port_c_pin_four_o,
	output logic                                     port_c_pin_four_oe,
	output logic                                     port_c_pin_four_pu,
	output logic                                     port_c_pin_four_pd,
	output logic                                     debug_clock_pin_o,
	output logic                                     debug_clock_pin_oe,
	output logic                                     debug_clock_pin_pu,
	output logic                                     debug_clock_pin_pd,
	// Inputs delivered to peripherals and core
	output logic                                     ctrl1_spi_master_in,
	output logic                                     ctrl1_spi_slave_in,
	output logic                                     ctrl1_twowire_clock,
	output logic                                     ctrl1_uart_receive,
	output logic                                     timer_two_channel_two,
	output logic                                     boundary_test_data_in,
	output logic                                     boundary_test_mode_select,
	output logic                                     wire_data_in,
	output logic [3:0]                               gpio_in,
	output logic                                     debug_wire_mode
);

	// ***************************************************************
	// Link domain: debug port mode
	// ***************************************************************
	// The reset pin forces JTAG even while the link clock stands still
	logic                           link_rst_n;
	logic                           link_sel_s;
	logic [dspm_pkg::ONES_W-1:0]    ones_q;
	logic [dspm_pkg::ONES_W-1:0]    ones_d;
	logic                           armed_q;
	logic [dspm_pkg::SEQ_W-1:0]     seq_q;
	logic [dspm_pkg::SEQ_W-1:0]     seq_d;
	dspm_pkg::dspm_link_e           link_q;

	assign link_rst_n = rst_n & external_reset_n;

	dspm_sync #(.W(1)) u_link_sync (
		.clk      (debug_link_clk),
		.rst_n    (link_rst_n),
		.async_in (port_c_pin_four_i),
		.sync_out (link_sel_s)
	);

	assign seq_d  = {link_sel_s, seq_q[dspm_pkg::SEQ_W-1:1]};
	assign ones_d = (ones_q == dspm_pkg::LINE_RESET_ONES) ? ones_q
	              : ones_q + 6'h01;

	// Line reset: a long run of ones arms the switch detector
	always_ff @(posedge debug_link_clk or negedge link_rst_n) begin
		if (!link_rst_n) begin
			ones_q <= '0;
		end else if (link_sel_s) begin
			ones_q <= ones_d;
		end else begin
			ones_q <= '0;
		end
	end

	always_ff @(posedge debug_link_clk or negedge link_rst_n) begin
		if (!link_rst_n) begin
			seq_q <= '0;
		end else begin
			seq_q <= seq_d;
		end
	end

	always_ff @(posedge debug_link_clk or negedge link_rst_n) begin
		if (!link_rst_n) begin
			armed_q <= 1'b0;
		end else if (ones_q == dspm_pkg::LINE_RESET_ONES) begin
			armed_q <= 1'b1;
		end else if (seq_q == dspm_pkg::SEQ_TO_WIRE || seq_q == dspm_pkg::SEQ_TO_JTAG) begin
			armed_q <= 1'b0;
		end
	end

	// Switch sequence is sent by the debugger, shifted in LSB first
	always_ff @(posedge debug_link_clk or negedge link_rst_n) begin
		if (!link_rst_n) begin
			link_q <= dspm_pkg::DSPM_LINK_JTAG;
		end else begin
			case (link_q)
				dspm_pkg::DSPM_LINK_JTAG: begin
					if (armed_q && seq_q == dspm_pkg::SEQ_TO_WIRE) begin
						link_q <= dspm_pkg::DSPM_LINK_WIRE;
					end
				end
				dspm_pkg::DSPM_LINK_WIRE: begin
					if (armed_q && seq_q == dspm_pkg::SEQ_TO_JTAG) begin
						link_q <= dspm_pkg::DSPM_LINK_JTAG;
					end
				end
				default: begin
					link_q <= dspm_pkg::DSPM_LINK_JTAG;
				end
			endcase
		end
	end

	// ***************************************************************
	// Crossing into the reference clock domain
	// ***************************************************************
	logic       wire_mode_raw;
	logic       wire_mode;
	logic [3:0] pins_s;
	logic       pb2_s;
	logic       pc2_s;
	logic       pc3_s;
	logic       pc4_s;

	assign wire_mode_raw = (link_q == dspm_pkg::DSPM_LINK_WIRE);

	dspm_sync #(.W(1)) u_mode_sync (
		.clk      (ref_clk),
		.rst_n    (rst_n),
		.async_in (wire_mode_raw),
		.sync_out (wire_mode)
	);

	dspm_sync #(.W(4)) u_pin_sync (
		.clk      (ref_clk),
		.rst_n    (rst_n),
		.async_in ({port_c_pin_four_i, port_c_pin_three_i,
		            port_c_pin_two_i, port_b_pin_two_i}),
		.sync_out (pins_s)
	);

	assign pb2_s = pins_s[0];
	assign pc2_s = pins_s[1];
	assign pc3_s = pins_s[2];
	assign pc4_s = pins_s[3];

	// ***************************************************************
	// Selection terms
	// ***************************************************************
	logic [3:0] pb2_field;
	logic [3:0] pc2_field;
	logic [3:0] pc3_field;
	logic [3:0] pa_field;
	logic       remap;
	logic       dbg_gpio;
	logic       twi_sel;
	logic       tim_out_sel;
	logic       pc2_gpio;
	logic       pc2_async;
	logic       pc2_sync;
	logic       pc3_gpio;
	logic       pc3_clk;
	logic       pc4_gpio;

	assign pb2_field = port_b_config_low[dspm_pkg::PB2_FIELD_LSB +: dspm_pkg::FIELD_W];
	assign pc2_field = port_c_config_low[dspm_pkg::PC2_FIELD_LSB +: dspm_pkg::FIELD_W];
	assign pc3_field = port_c_config_low[dspm_pkg::PC3_FIELD_LSB +: dspm_pkg::FIELD_W];
	assign pa_field  = port_a_config_low[dspm_pkg::PA_TRACE_LSB +: dspm_pkg::FIELD_W];
	assign remap     = timer_two_remap_option[dspm_pkg::REMAP_CH2_BIT];
	assign dbg_gpio  = debug_pin_config[dspm_pkg::DBG_GPIO_BIT];

	assign twi_sel     = (ctrl1_mode_select == dspm_pkg::CTRL1_MODE_TWI)
	                   && (pb2_field == dspm_pkg::FIELD_ALT_OD)
	                   && (!timer_two_output_enable || !remap);
	assign tim_out_sel = remap && timer_two_output_enable
	                   && (pb2_field == dspm_pkg::FIELD_ALT_OUT);

	assign pc2_gpio  = dbg_gpio && !port_c_config_high[dspm_pkg::PC_HIGH_BIT];
	assign pc2_async = trace_enable && trace_async_select && wire_mode
	                 && (pc2_field == dspm_pkg::FIELD_ALT_OUT);
	assign pc2_sync  = trace_enable && trace_sync4_select
	                 && (pa_field == dspm_pkg::FIELD_ALT_OUT);
	assign pc3_clk   = trace_enable && (pc3_field == dspm_pkg::FIELD_ALT_OUT);
	assign pc3_gpio  = dbg_gpio || wire_mode;
	assign pc4_gpio  = dbg_gpio;

	// ***************************************************************
	// Pad drive selection
	// ***************************************************************
	logic [3:0] o_d;
	logic [3:0] oe_d;
	logic [3:0] pu_d;
	logic [3:0] pd_d;

	// Port B pin two; the two-wire clock is open drain, driven only low
	always_comb begin
		if (twi_sel) begin
			o_d[0]  = 1'b0;
			oe_d[0] = ctrl1_twowire_clock_low;
		end else if (tim_out_sel) begin
			o_d[0]  = timer_two_channel_two_out;
			oe_d[0] = 1'b1;
		end else begin
			o_d[0]  = gpio_out[0];
			oe_d[0] = gpio_out_en[0];
		end
		pu_d[0] = 1'b0;
		pd_d[0] = 1'b0;
	end

	// Port C pin two; configured trace outranks the JTAG default
	always_comb begin
		pu_d[1] = 1'b0;
		pd_d[1] = 1'b0;
		if (pc2_gpio) begin
			o_d[1]  = gpio_out[1];
			oe_d[1] = gpio_out_en[1];
		end else if (pc2_async) begin
			o_d[1]  = async_trace_out;
			oe_d[1] = 1'b1;
			pu_d[1] = 1'b1;
		end else if (pc2_sync) begin
			o_d[1]  = sync_trace_data_zero;
			oe_d[1] = 1'b1;
		end else if (!wire_mode) begin
			o_d[1]  = boundary_test_data_out;
			oe_d[1] = boundary_test_data_out_en;
		end else begin
			o_d[1]  = gpio_out[1];
			oe_d[1] = gpio_out_en[1];
		end
	end

	// Port C pin three; trace clock outranks the general I/O fallback
	always_comb begin
		pu_d[2] = 1'b0;
		pd_d[2] = 1'b0;
		if (pc3_clk) begin
			o_d[2]  = sync_trace_clock;
			oe_d[2] = 1'b1;
		end else if (pc3_gpio) begin
			o_d[2]  = gpio_out[2];
			oe_d[2] = gpio_out_en[2];
		end else begin
			o_d[2]  = 1'b0;
			oe_d[2] = 1'b0;
			pu_d[2] = 1'b1;
		end
	end

	// Port C pin four
	always_comb begin
		pd_d[3] = 1'b0;
		if (pc4_gpio) begin
			o_d[3]  = gpio_out[3];
			oe_d[3] = gpio_out_en[3];
			pu_d[3] = 1'b0;
		end else if (wire_mode) begin
			o_d[3]  = wire_data_out;
			oe_d[3] = wire_data_out_en;
			pu_d[3] = 1'b1;
		end else begin
			o_d[3]  = 1'b0;
			oe_d[3] = 1'b0;
			pu_d[3] = 1'b1;
		end
	end

	dspm_pad u_pad_b2 (
		.clk   (ref_clk),
		.rst_n (rst_n),
		.o_d   (o_d[0]),
		.oe_d  (oe_d[0]),
		.pu_d  (pu_d[0]),
		.pd_d  (pd_d[0]),
		.o_q   (port_b_pin_two_o),
		.oe_q  (port_b_pin_two_oe),
		.pu_q  (port_b_pin_two_pu),
		.pd_q  (port_b_pin_two_pd)
	);

	dspm_pad u_pad_c2 (
		.clk   (ref_clk),
		.rst_n (rst_n),
		.o_d   (o_d[1]),
		.oe_d  (oe_d[1]),
		.pu_d  (pu_d[1]),
		.pd_d  (pd_d[1]),
		.o_q   (port_c_pin_two_o),
		.oe_q  (port_c_pin_two_oe),
		.pu_q  (port_c_pin_two_pu),
		.pd_q  (port_c_pin_two_pd)
	);

	dspm_pad u_pad_c3 (
		.clk   (ref_clk),
		.rst_n (rst_n),
		.o_d   (o_d[2]),
		.oe_d  (oe_d[2]),
		.pu_d  (pu_d[2]),
		.pd_d  (pd_d[2]),
		.o_q   (port_c_pin_three_o),
		.oe_q  (port_c_pin_three_oe),
		.pu_q  (port_c_pin_three_pu),
		.pd_q  (port_c_pin_three_pd)
	);

	dspm_pad u_pad_c4 (
		.clk   (ref_clk),
		.rst_n (rst_n),
		.o_d   (o_d[3]),
		.oe_d  (oe_d[3]),
		.pu_d  (pu_d[3]),
		.pd_d  (pd_d[3]),
		.o_q   (port_c_pin_four_o),
		.oe_q  (port_c_pin_four_oe),
		.pu_q  (port_c_pin_four_pu),
		.pd_q  (port_c_pin_four_pd)
	);

	// Debug clock pin: the device never drives it, it only clocks the link
	dspm_pad u_pad_dclk (
		.clk   (ref_clk),
		.rst_n (rst_n),
		.o_d   (1'b0),
		.oe_d  (1'b0),
		.pu_d  (1'b0),
		.pd_d  (!wire_mode),
		.o_q   (debug_clock_pin_o),
		.oe_q  (debug_clock_pin_oe),
		.pu_q  (debug_clock_pin_pu),
		.pd_q  (debug_clock_pin_pd)
	);

	// ***************************************************************
	// Inputs toward peripherals and core
	// ***************************************************************
	// Unselected inputs read zero so a peripheral never sees a foreign pin
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			ctrl1_spi_master_in <= 1'b0;
			ctrl1_spi_slave_in  <= 1'b0;
			ctrl1_uart_receive  <= 1'b0;
		end else begin
			ctrl1_spi_master_in <= (ctrl1_mode_select == dspm_pkg::CTRL1_MODE_SPI)
			                    && ctrl1_spi_config && pb2_s;
			ctrl1_spi_slave_in  <= (ctrl1_mode_select == dspm_pkg::CTRL1_MODE_SPI)
			                    && !ctrl1_spi_config && pb2_s;
			ctrl1_uart_receive  <= (ctrl1_mode_select == dspm_pkg::CTRL1_MODE_UART)
			                    && pb2_s;
		end
	end

	// Idle two-wire clock and idle timer input read high and low
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			ctrl1_twowire_clock   <= 1'b1;
			timer_two_channel_two <= 1'b0;
		end else begin
			ctrl1_twowire_clock   <= twi_sel ? pb2_s : 1'b1;
			timer_two_channel_two <= remap && pb2_s;
		end
	end

	// Pulled-up JTAG and wire-mode data inputs read high while not routed
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			boundary_test_data_in     <= 1'b1;
			boundary_test_mode_select <= 1'b1;
			wire_data_in              <= 1'b1;
		end else begin
			boundary_test_data_in     <= (!wire_mode && !pc3_gpio && !pc3_clk) ? pc3_s
			                          : 1'b1;
			boundary_test_mode_select <= (!wire_mode && !pc4_gpio) ? pc4_s
			                          : 1'b1;
			wire_data_in              <= (wire_mode && !pc4_gpio) ? pc4_s
			                          : 1'b1;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			gpio_in         <= '0;
			debug_wire_mode <= 1'b0;
		end else begin
			gpio_in         <= pins_s;
			debug_wire_mode <= wire_mode;
		end
	end

endmodule : dspm_pin_mux

/* File: core/dspm_pkg.sv */
// Constants shared by the debug and serial pin mux
package dspm_pkg;

	// ***************************************************************
	// Serial controller one mode field
	// ***************************************************************
	localparam logic [1:0] CTRL1_MODE_OFF  = 2'h0;
	localparam logic [1:0] CTRL1_MODE_UART = 2'h1;
	localparam logic [1:0] CTRL1_MODE_SPI  = 2'h2;
	localparam logic [1:0] CTRL1_MODE_TWI  = 2'h3;

	// ***************************************************************
	// Pin configuration fields and bit positions
	// ***************************************************************
	localparam int          CFG_W          = 16;
	localparam int          FIELD_W        = 4;
	localparam int          PB2_FIELD_LSB  = 8;
	localparam int          PC2_FIELD_LSB  = 8;
	localparam int          PC3_FIELD_LSB  = 12;
	localparam int          PA_TRACE_LSB   = 8;
	localparam int          DBG_CFG_W      = 8;
	localparam int          DBG_GPIO_BIT   = 5;
	localparam int          PC_HIGH_BIT    = 1;
	localparam int          REMAP_W        = 8;
	localparam int          REMAP_CH2_BIT  = 5;
	localparam logic [3:0]  FIELD_ALT_OUT  = 4'h9;
	localparam logic [3:0]  FIELD_ALT_OD   = 4'hd;

	// ***************************************************************
	// Debug link protocol
	// ***************************************************************
	localparam int          SYNC_STAGES    = 2;
	localparam int          ONES_W         = 6;
	localparam logic [5:0]  LINE_RESET_ONES = 6'h32;
	localparam int          SEQ_W          = 16;
	localparam logic [15:0] SEQ_TO_WIRE    = 16'he79e;
	localparam logic [15:0] SEQ_TO_JTAG    = 16'he73c;

	typedef enum logic {
		DSPM_LINK_JTAG,
		DSPM_LINK_WIRE
	} dspm_link_e;

endpackage : dspm_pkg

/* File: core/dspm_sync.sv */
// Two-stage synchroniser for levels entering a clock domain
`timescale 1ns/1ps
module dspm_sync #(
	parameter int W = 1
) (
	input  wire logic         clk,
	input  wire logic         rst_n,
	input  wire logic [W-1:0] async_in,
	output logic      [W-1:0] sync_out
);

	logic [W-1:0] meta_q;

	// First stage feeds only the second stage
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			meta_q   <= '0;
			sync_out <= '0;
		end else begin
			meta_q   <= async_in;
			sync_out <= meta_q;
		end
	end

endmodule : dspm_sync

/* File: core/dspm_pad.sv */
// Registered drive, enable and pull controls of one pad
`timescale 1ns/1ps
module dspm_pad (
	input  wire logic clk,
	input  wire logic rst_n,
	input  wire logic o_d,
	input  wire logic oe_d,
	input  wire logic pu_d,
	input  wire logic pd_d,
	output logic      o_q,
	output logic      oe_q,
	output logic      pu_q,
	output logic      pd_q
);

	// Reset leaves the pad undriven with no pull
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			o_q  <= 1'b0;
			oe_q <= 1'b0;
			pu_q <= 1'b0;
			pd_q <= 1'b0;
		end else begin
			o_q  <= o_d;
			oe_q <= oe_d;
			pu_q <= pu_d;
			pd_q <= pd_d;
		end
	end

endmodule : dspm_pad

/* File: test/dspm_pin_mux_sva.sv */
// Assertion checker for the debug and serial pin mux
`timescale 1ns/1ps
module dspm_pin_mux_sva (
	input wire logic        ref_clk,
	input wire logic        rst_n,
	input wire logic        external_reset_n,
	input wire logic [1:0]  ctrl1_mode_select,
	input wire logic        ctrl1_spi_config,
	input wire logic        timer_two_output_enable,
	input wire logic [7:0]  timer_two_remap_option,
	input wire logic [15:0] port_b_config_low,
	input wire logic [15:0] port_c_config_low,
	input wire logic [7:0]  debug_pin_config,
	input wire logic        trace_enable,
	input wire logic        ctrl1_twowire_clock_low,
	input wire logic        timer_two_channel_two_out,
	input wire logic [3:0]  gpio_out,
	input wire logic [3:0]  gpio_out_en,
	input wire logic        port_b_pin_two_i,
	input wire logic        port_b_pin_two_o,
	input wire logic        port_b_pin_two_oe,
	input wire logic        port_c_pin_three_oe,
	input wire logic        port_c_pin_four_o,
	input wire logic        port_c_pin_four_oe,
	input wire logic        debug_clock_pin_oe,
	input wire logic        debug_clock_pin_pd,
	input wire logic        ctrl1_spi_master_in,
	input wire logic        ctrl1_uart_receive,
	input wire logic        debug_wire_mode
);
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!rst_n);
	// Timer claims pin B2 only when remapped and enabled
	wire       tmr_on = timer_two_remap_option[5] && timer_two_output_enable;
	wire [3:0] fb     = port_b_config_low[11:8];
	wire [1:0] md     = ctrl1_mode_select;
	a_b2_timer_out: assert property (
		(tmr_on && fb == 4'h9 && $stable(timer_two_channel_two_out))[*2]
		|-> port_b_pin_two_oe && port_b_pin_two_o == timer_two_channel_two_out)
		else $error("timer");
	a_b2_twi_clock: assert property (
		(md == 2'h3 && fb == 4'hd && !tmr_on && $stable(ctrl1_twowire_clock_low))[*2]
		|-> port_b_pin_two_oe == ctrl1_twowire_clock_low && !port_b_pin_two_o)
		else $error("twi");
	a_spi_master_in: assert property (
		(md == 2'h2 && ctrl1_spi_config && $stable(port_b_pin_two_i))[*4]
		|-> ctrl1_spi_master_in == port_b_pin_two_i)
		else $error("spi in");
	a_uart_rx_path: assert property (
		(md == 2'h1 && $stable(port_b_pin_two_i))[*4]
		|-> ctrl1_uart_receive == port_b_pin_two_i)
		else $error("uart in");
	a_dbg_clk_pull: assert property (
		(!debug_wire_mode)[*3]
		|-> debug_clock_pin_pd && !debug_clock_pin_oe)
		else $error("tck pull");
	a_ext_reset_jtag: assert property (
		$fell(external_reset_n) |-> ##[1:4] !debug_wire_mode)
		else $error("jtag reset");
	a_c4_gpio_out: assert property (
		(debug_pin_config[5] && $stable({gpio_out, gpio_out_en}))[*2]
		|-> port_c_pin_four_o == gpio_out[3] && port_c_pin_four_oe == gpio_out_en[3])
		else $error("c4");
	a_c3_trace_clk: assert property (
		(trace_enable && port_c_config_low[15:12] == 4'h9)[*2]
		|-> port_c_pin_three_oe)
		else $error("c3 trace");
	c_wire_mode: cover property ($rose(debug_wire_mode));
	c_timer_pin: cover property (tmr_on && port_b_pin_two_oe);
	c_trace_clk: cover property (trace_enable && port_c_pin_three_oe);
endmodule : dspm_pin_mux_sva

bind dspm_pin_mux dspm_pin_mux_sva u_sva (.*);

/* File: test/dspm_probe.sv */
// Debugger probe model driving the debug clock and mode-select line
`timescale 1ns/1ps
module dspm_probe (
	output logic tck,
	output logic tms
);
	// Clock rests low between frames; the released line reads as its pull-up
	initial begin
		tck = 1'b0;
		tms = 1'b1;
	end
	task automatic bit_out(input logic b);
		tms = b;
		#16 tck = 1'b1;
		#16 tck = 1'b0;
	endtask : bit_out
	// Line reset, the code bit 0 first, then idle clocks to flush the pipeline
	task automatic switch_to(input logic [15:0] code);
		for (int i = 0; i < 56; i++) bit_out(1'b1);
		for (int i = 0; i < 16; i++) bit_out(code[i]);
		for (int i = 0; i < 4; i++) bit_out(1'b1);
	endtask : switch_to
endmodule : dspm_probe

/* File: test/dspm_pin_mux_tb.sv */
// Self-checking bench for the debug and serial pin mux
`timescale 1ns/1ps
module dspm_pin_mux_tb;
	logic        ref_clk, rst_n, external_reset_n, ctrl1_spi_config, b2, debug_link_clk, tms;
	logic        timer_two_output_enable, trace_enable, trace_async_select, trace_sync4_select;
	logic [1:0]  ctrl1_mode_select;
	logic [7:0]  timer_two_remap_option, debug_pin_config;
	logic [15:0] port_a_config_low, port_b_config_low, port_c_config_low, port_c_config_high;
	logic [3:0]  gpio_out, gpio_out_en, gpio_in;
	logic [8:0]  dv;
	logic        ctrl1_twowire_clock_low, timer_two_channel_two_out, boundary_test_data_out;
	logic        boundary_test_data_out_en, async_trace_out, sync_trace_data_zero;
	logic        sync_trace_clock, wire_data_out, wire_data_out_en, debug_wire_mode;
	logic        port_b_pin_two_i, port_b_pin_two_o, port_b_pin_two_oe, port_b_pin_two_pu;
	logic        port_b_pin_two_pd, port_c_pin_two_i, port_c_pin_two_o, port_c_pin_two_oe;
	logic        port_c_pin_two_pu, port_c_pin_two_pd, port_c_pin_three_i, port_c_pin_three_o;
	logic        port_c_pin_three_oe, port_c_pin_three_pu, port_c_pin_three_pd, port_c_pin_four_i;
	logic        port_c_pin_four_o, port_c_pin_four_oe, port_c_pin_four_pu, port_c_pin_four_pd;
	logic        debug_clock_pin_o, debug_clock_pin_oe, debug_clock_pin_pu, debug_clock_pin_pd;
	logic        ctrl1_spi_master_in, ctrl1_spi_slave_in, ctrl1_twowire_clock, ctrl1_uart_receive;
	logic        timer_two_channel_two, boundary_test_data_in, boundary_test_mode_select;
	logic        wire_data_in;
	int          n_fail = 0;
	int          n_tests = 0;
	int          cyc = 0;
	assign {ctrl1_twowire_clock_low, timer_two_channel_two_out, boundary_test_data_out,
		boundary_test_data_out_en, async_trace_out, sync_trace_data_zero, sync_trace_clock,
		wire_data_out, wire_data_out_en} = dv;
	assign port_b_pin_two_i = port_b_pin_two_oe ? port_b_pin_two_o : b2;
	assign port_c_pin_two_i = port_c_pin_two_oe ? port_c_pin_two_o : b2;
	assign port_c_pin_three_i = port_c_pin_three_oe ? port_c_pin_three_o : b2;
	assign port_c_pin_four_i = port_c_pin_four_oe ? port_c_pin_four_o : tms;
	dspm_pin_mux u_dut (.*);
	dspm_probe u_probe (.tck(debug_link_clk), .tms(tms));
	initial begin
		ref_clk = 1'b0;
		forever #20 ref_clk = ~ref_clk;
	end
	task automatic w(input int n);
		repeat (n) @(negedge ref_clk);
	endtask : w
	task automatic chk(input logic [15:0] g, input logic [15:0] e);
		n_tests++;
		if (g !== e) begin
			n_fail++;
			$display("wrong value at %0t: got %h expected %h", $time, g, e);
		end
	endtask : chk
	task automatic finish_test();
		$display("checks %0d mismatches %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : finish_test
	task automatic t_reset();
		chk({debug_wire_mode, debug_clock_pin_pd, debug_clock_pin_oe}, 16'h2);
		chk({debug_clock_pin_o, debug_clock_pin_pu}, 16'h0);
		chk({port_c_pin_three_pu, port_c_pin_four_pu}, 16'h3);
		dv = 9'h060;
		w(2);
		chk({port_c_pin_two_oe, port_c_pin_two_o}, 16'h3);
		chk({boundary_test_data_in, boundary_test_mode_select, wire_data_in, ctrl1_twowire_clock},
		    16'h7);
		chk(boundary_test_data_in, 16'h0);
		chk({boundary_test_mode_select, wire_data_in}, 16'h3);
		$display("test reset done");
	endtask : t_reset
	task automatic t_b2();
		b2 = 1'b1;
		ctrl1_mode_select = 2'h2;
		ctrl1_spi_config = 1'b1;
		w(5);
		chk({ctrl1_spi_master_in, ctrl1_spi_slave_in, ctrl1_uart_receive}, 16'h4);
		ctrl1_spi_config = 1'b0;
		w(4);
		chk({ctrl1_spi_master_in, ctrl1_spi_slave_in, ctrl1_uart_receive}, 16'h2);
		ctrl1_mode_select = 2'h1;
		timer_two_remap_option = 8'h20;
		w(4);
		chk({ctrl1_uart_receive, timer_two_channel_two}, 16'h3);
		timer_two_output_enable = 1'b1;
		port_b_config_low = 16'h0900;
		dv = 9'h080;
		w(3);
		chk({port_b_pin_two_oe, port_b_pin_two_o}, 16'h3);
		ctrl1_mode_select = 2'h3;
		port_b_config_low = 16'h0d00;
		dv = 9'h100;
		w(2);
		chk(port_b_pin_two_oe, 16'h0);
		timer_two_remap_option = 8'h00;
		w(2);
		chk({port_b_pin_two_oe, port_b_pin_two_o}, 16'h2);
		w(2);
		chk({ctrl1_twowire_clock, timer_two_channel_two}, 16'h0);
		ctrl1_mode_select = 2'h0;
		$display("test pin b2 done");
	endtask : t_b2
	task automatic t_gpio();
		debug_pin_config = 8'h20;
		gpio_out = 4'ha;
		gpio_out_en = 4'hf;
		w(2);
		chk({port_c_pin_four_o, port_c_pin_two_o}, 16'h3);
		chk({port_c_pin_three_o, port_b_pin_two_oe}, 16'h1);
		port_c_config_high = 16'h0002;
		dv = 9'h020;
		w(2);
		chk(port_c_pin_two_o, 16'h0);
		chk(gpio_in, 16'ha);
		{debug_pin_config, port_c_config_high, gpio_out_en} = '0;
		$display("test gpio done");
	endtask : t_gpio
	task automatic t_trace();
		trace_enable = 1'b1;
		trace_sync4_select = 1'b1;
		port_a_config_low = 16'h0900;
		dv = 9'h008;
		w(2);
		chk({port_c_pin_two_oe, port_c_pin_two_o}, 16'h3);
		port_c_config_low = 16'h9000;
		dv = 9'h004;
		w(2);
		chk({port_c_pin_three_oe, port_c_pin_three_o}, 16'h3);
		{trace_sync4_select, port_a_config_low} = '0;
		$display("test trace done");
	endtask : t_trace
	task automatic t_link();
		port_c_config_low = 16'h0900;
		trace_async_select = 1'b1;
		dv = 9'h010;
		u_probe.switch_to(16'he79e);
		w(4);
		chk({debug_wire_mode, debug_clock_pin_pd, port_c_pin_four_pu}, 16'h5);
		chk({port_c_pin_two_oe, port_c_pin_two_o, port_c_pin_two_pu}, 16'h7);
		gpio_out = 4'h4;
		gpio_out_en = 4'h4;
		w(2);
		chk({port_c_pin_three_oe, port_c_pin_three_o}, 16'h3);
		external_reset_n = 1'b0;
		w(1);
		external_reset_n = 1'b1;
		w(4);
		chk(debug_wire_mode, 16'h0);
		$display("test link done");
	endtask : t_link
	// Cut a hang short; the whole run needs well under 1000 cycles
	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == 3000) begin
			n_fail++;
			finish_test();
		end
	end
	initial begin
		{rst_n, b2, ctrl1_spi_config, timer_two_output_enable, trace_enable, trace_async_select} = '0;
		{trace_sync4_select, ctrl1_mode_select, timer_two_remap_option, debug_pin_config} = '0;
		{port_a_config_low, port_b_config_low, port_c_config_low, port_c_config_high} = '0;
		{gpio_out, gpio_out_en, dv} = '0;
		external_reset_n = 1'b1;
		w(3);
		rst_n = 1'b1;
		w(2);
		t_reset();
		t_b2();
		t_gpio();
		t_trace();
		t_link();
		finish_test();
	end
endmodule : dspm_pin_mux_tb
